// File: gpio_board_model.sv
// Board devices facing ports five and six
`timescale 1ns/1ps
`default_nettype none
module gpio_board_model (
    input wire logic [3:0] five_out,
    input wire logic [3:0] five_oe,
    input wire logic [3:0] five_ext,
    input wire logic [2:0] six_out,
    input wire logic [2:0] six_oe,
    input wire logic [2:0] six_ext,
    output logic [3:0] five_level,
    output logic [2:0] six_level
);
    // Board drives every pin the block leaves as input, so none floats
    assign five_level = (five_oe & five_out) | (~five_oe & five_ext);
    assign six_level = (six_oe & six_out) | (~six_oe & six_ext);
endmodule
`default_nettype wire

// File: gpio_ports_five_six.sv
// Ports five and six: registers, pin drivers, pull-ups, bus-release pins
//
// How it works
// [R1] 1-Mbyte modes: upper port-five pin outputs when direction bit set.
// [R2] 16-Mbyte modes: port-five direction reads fixed ff, writes ignored.
// [R3] 16-Mbyte modes: port-five pins driven from the address bus.
// [R4] 1-Mbyte modes: port-five direction is write-only, reads all ones.
// [R5] Reset/hardware standby load 0f into port-five direction; standby keeps.
// [R6] Port-five data read: latch for output pins, pin level for inputs.
// [R7] Port-five data bits 3..0 are plain storage, no pin.
// [R8] Reset/hardware standby clear port-five data; software standby keeps.
// [R9] 1-Mbyte modes: pull-up on when control bit 1 and direction 0.
// [R10] Pull-up control bits 3..0 are plain storage, drive no pull-up.
// [R11] Reset/hardware standby clear pull-up control; software standby keeps.
// [R12] Reset/hardware standby switch pull-ups off; software standby keeps.
// [R13] 16-Mbyte modes: all port-five pull-ups stay off.
// [R14] Port-six pins 2..0 follow direction bits; bits 7..3 reserved.
// [R15] Port-six direction is write-only, reads all ones.
// [R16] Reset/hardware standby load 80 into port-six direction; standby keeps.
// [R17] Port-six data read: latch for output pins, pin level for inputs.
// [R18] Port-six data bit 7 fixed at 1; bits 6..3 storage only.
// [R19] Reset/hardware standby load 80 into port-six data; standby keeps.
// [R20] Bus-release enable: pin 2 is acknowledge out, pin 1 request in.
// [R21] 1-Mbyte modes: port-five direction bits 3..0 stay at one.
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "gpio_ports_five_six_map.svh"

module gpio_ports_five_six #(
    parameter int SYNC_STAGES = 3
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic hw_standby,
    input wire gpio_ports_five_six_pkg::op_mode_e op_mode,
    input wire logic [15:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    input wire logic [3:0] address_bus_upper,
    input wire logic [3:0] port_five_pin_in,
    output logic [3:0] port_five_pin_out,
    output logic [3:0] port_five_pin_oe,
    output logic [3:0] port_five_pullup_on,
    input wire logic [2:0] port_six_pin_in,
    output logic [2:0] port_six_pin_out,
    output logic [2:0] port_six_pin_oe,
    input wire logic bus_acknowledge,
    output logic bus_release_request,
    output logic bus_release_enable
);

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    if (SYNC_STAGES != 3) begin : g_bad_sync
        $error("SYNC_STAGES must be 3");
    end

    // ------------------------------------------------------------------
    // Mode decode and init condition
    // ------------------------------------------------------------------
    logic wide_mode;
    logic init;
    assign wide_mode = op_mode[1];
    // Hardware standby initialises the registers as reset does, but not the synchronisers or read data
    assign init = !reset_n || hw_standby;

    // ------------------------------------------------------------------
    // Register write decode
    // ------------------------------------------------------------------
    // Full 16-bit match, so aliases never hit a register
    logic wr_p5_dir;
    logic wr_p6_dir;
    logic wr_p5_lat;
    logic wr_p6_lat;
    logic wr_p5_pcr;
    logic wr_brc;
    assign wr_p5_dir = reg_write && reg_addr == `PORT_FIVE_DIRECTION_ADDR;
    assign wr_p6_dir = reg_write && reg_addr == `PORT_SIX_DIRECTION_ADDR;
    assign wr_p5_lat = reg_write && reg_addr == `PORT_FIVE_OUTPUT_LATCH_ADDR;
    assign wr_p6_lat = reg_write && reg_addr == `PORT_SIX_OUTPUT_LATCH_ADDR;
    assign wr_p5_pcr = reg_write &&
        reg_addr == `PORT_FIVE_PULLUP_CONTROL_ADDR;
    assign wr_brc = reg_write && reg_addr == `BUS_RELEASE_CONTROL_ADDR;

    // ------------------------------------------------------------------
    // Pin input synchronisers
    // ------------------------------------------------------------------
    logic [3:0] p5_s1;
    logic [3:0] p5_s2;
    logic [3:0] p5_s3;
    logic [3:0] p5_level;
    logic [2:0] p6_s1;
    logic [2:0] p6_s2;
    logic [2:0] p6_s3;
    logic [2:0] p6_level;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            p5_s1 <= 4'h0;
            p5_s2 <= 4'h0;
            p5_s3 <= 4'h0;
            p6_s1 <= 3'h0;
            p6_s2 <= 3'h0;
            p6_s3 <= 3'h0;
        end else begin
            p5_s1 <= port_five_pin_in;
            p5_s2 <= p5_s1;
            p5_s3 <= p5_s2;
            p6_s1 <= port_six_pin_in;
            p6_s2 <= p6_s1;
            p6_s3 <= p6_s2;
        end
    end

    // Level moves only once the second and third stages agree
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            p5_level <= 4'h0;
            p6_level <= 3'h0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (p5_s2[i] == p5_s3[i]) begin
                    p5_level[i] <= p5_s3[i];
                end
            end
            for (int i = 0; i < 3; i++) begin
                if (p6_s2[i] == p6_s3[i]) begin
                    p6_level[i] <= p6_s3[i];
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Port five registers
    // ------------------------------------------------------------------
    logic [7:0] port_five_direction;
    logic [7:0] port_five_output_latch;
    logic [7:0] port_five_pullup_control;
    logic [7:0] next_port_five_direction;
    logic [7:0] next_port_five_output_latch;
    logic [7:0] next_port_five_pullup_control;

    // Wide modes own the direction register, so writes there fall away
    always_comb begin
        next_port_five_direction = port_five_direction;
        if (wide_mode) begin
            next_port_five_direction = `PORT_FIVE_DIRECTION_WIDE; // R2
        end else if (wr_p5_dir) begin
            // Low nibble held at one
            next_port_five_direction = {reg_wdata[7:4], 4'hf}; // R1 R21
        end
    end

    always_ff @(posedge clk) begin
        if (init) begin
            port_five_direction <= `PORT_FIVE_DIRECTION_RESET; // R5
        end else begin
            port_five_direction <= next_port_five_direction;
        end
    end

    always_comb begin
        next_port_five_output_latch = port_five_output_latch;
        if (wr_p5_lat) begin
            next_port_five_output_latch = reg_wdata; // R7
        end
    end

    always_ff @(posedge clk) begin
        if (init) begin
            port_five_output_latch <= `PORT_FIVE_OUTPUT_LATCH_RESET; // R8
        end else begin
            port_five_output_latch <= next_port_five_output_latch;
        end
    end

    // Low control bits are kept so software reads back what it wrote
    always_comb begin
        next_port_five_pullup_control = port_five_pullup_control;
        if (wr_p5_pcr) begin
            next_port_five_pullup_control = reg_wdata; // R10
        end
    end

    always_ff @(posedge clk) begin
        if (init) begin
            port_five_pullup_control <= `PORT_FIVE_PULLUP_CONTROL_RESET; // R11
        end else begin
            port_five_pullup_control <= next_port_five_pullup_control;
        end
    end

    // ------------------------------------------------------------------
    // Port six registers
    // ------------------------------------------------------------------
    logic [7:0] port_six_direction;
    logic [7:0] port_six_output_latch;
    logic [7:0] next_port_six_direction;
    logic [7:0] next_port_six_output_latch;

    // Reserved top bit stays at its reset one
    always_comb begin
        next_port_six_direction = port_six_direction;
        if (wr_p6_dir) begin
            next_port_six_direction = {1'b1, reg_wdata[6:0]}; // R14
        end
    end

    always_ff @(posedge clk) begin
        if (init) begin
            port_six_direction <= `PORT_SIX_DIRECTION_RESET; // R16
        end else begin
            port_six_direction <= next_port_six_direction;
        end
    end

    always_comb begin
        next_port_six_output_latch = port_six_output_latch;
        if (wr_p6_lat) begin
            // Top bit cannot be modified
            next_port_six_output_latch = {1'b1, reg_wdata[6:0]}; // R18
        end
    end

    always_ff @(posedge clk) begin
        if (init) begin
            port_six_output_latch <= `PORT_SIX_OUTPUT_LATCH_RESET; // R19
        end else begin
            port_six_output_latch <= next_port_six_output_latch;
        end
    end

    // ------------------------------------------------------------------
    // Bus-release control
    // ------------------------------------------------------------------
    logic [7:0] bus_release_control_register;
    logic [7:0] next_bus_release_control_register;

    // Only the enable bit acts; the rest is plain storage
    always_comb begin
        next_bus_release_control_register = bus_release_control_register;
        if (wr_brc) begin
            next_bus_release_control_register = reg_wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (init) begin
            bus_release_control_register <= 8'h00;
        end else begin
            bus_release_control_register <= next_bus_release_control_register;
        end
    end

    assign bus_release_enable =
        bus_release_control_register[`BUS_RELEASE_ENABLE_BIT];

    // ------------------------------------------------------------------
    // Port five pin drive and pull-ups
    // ------------------------------------------------------------------
    logic [3:0] p5_dir_hi;
    logic [3:0] p5_pcr_hi;
    assign p5_dir_hi = port_five_direction[7:4];
    assign p5_pcr_hi = port_five_pullup_control[7:4];

    always_comb begin
        if (wide_mode) begin
            port_five_pin_out = address_bus_upper; // R3
            port_five_pin_oe = 4'hf; // R3
            port_five_pullup_on = 4'h0; // R13
        end else begin
            port_five_pin_out = port_five_output_latch[7:4];
            port_five_pin_oe = p5_dir_hi; // R1
            // Init clears the pull-up control register, so pull-ups fall off too
            port_five_pullup_on = p5_pcr_hi & ~p5_dir_hi; // R9 R12
        end
    end

    // ------------------------------------------------------------------
    // Port six pin drive and bus-release sharing
    // ------------------------------------------------------------------
    logic [2:0] p6_dir;
    assign p6_dir = port_six_direction[2:0];

    always_comb begin
        port_six_pin_out = port_six_output_latch[2:0];
        port_six_pin_oe = p6_dir; // R14
        if (bus_release_enable) begin
            port_six_pin_out[`PORT_SIX_ACK_BIT] = bus_acknowledge; // R20
            port_six_pin_oe[`PORT_SIX_ACK_BIT] = 1'b1; // R20
            port_six_pin_oe[`PORT_SIX_REQ_BIT] = 1'b0; // R20
        end
    end

    // Request is only meaningful while the release function owns the pin
    assign bus_release_request = bus_release_enable &&
        p6_level[`PORT_SIX_REQ_BIT]; // R20

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    logic [7:0] p5_read;
    logic [7:0] p6_read;
    assign p5_read = {(port_five_output_latch[7:4] & p5_dir_hi) |
        (p5_level & ~p5_dir_hi), port_five_output_latch[3:0]}; // R6 R7
    assign p6_read = {port_six_output_latch[7:3],
        (port_six_output_latch[2:0] & p6_dir) |
        (p6_level & ~p6_dir)}; // R17 R18

    logic [7:0] next_reg_rdata;

    // Idle cycles return 00 so stale read data never lingers on the bus
    always_comb begin
        next_reg_rdata = `UNMAPPED_READ;
        if (reg_read) begin
            unique case (reg_addr)
                `PORT_FIVE_DIRECTION_ADDR: begin
                    next_reg_rdata = `WRITE_ONLY_READ; // R2 R4
                end
                `PORT_SIX_DIRECTION_ADDR: begin
                    next_reg_rdata = `WRITE_ONLY_READ; // R15
                end
                `PORT_FIVE_OUTPUT_LATCH_ADDR: begin
                    next_reg_rdata = p5_read;
                end
                `PORT_SIX_OUTPUT_LATCH_ADDR: begin
                    next_reg_rdata = p6_read;
                end
                `PORT_FIVE_PULLUP_CONTROL_ADDR: begin
                    next_reg_rdata = port_five_pullup_control;
                end
                `BUS_RELEASE_CONTROL_ADDR: begin
                    next_reg_rdata = bus_release_control_register;
                end
                default: begin
                    next_reg_rdata = `UNMAPPED_READ;
                end
            endcase
        end
    end

    // Registered so the answer stands exactly one cycle after the strobe
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            reg_rdata <= `UNMAPPED_READ;
        end else begin
            reg_rdata <= next_reg_rdata;
        end
    end

endmodule
`default_nettype wire

// File: gpio_ports_five_six_checker.sv
// Port-level assertions for the port five and six block
`timescale 1ns/1ps
`default_nettype none
`include "gpio_ports_five_six_map.svh"
module gpio_ports_five_six_checker (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic hw_standby,
    input wire gpio_ports_five_six_pkg::op_mode_e op_mode,
    input wire logic [15:0] reg_addr,
    input wire logic reg_read,
    input wire logic [7:0] reg_rdata,
    input wire logic [3:0] address_bus_upper,
    input wire logic [3:0] port_five_pin_out,
    input wire logic [3:0] port_five_pin_oe,
    input wire logic [3:0] port_five_pullup_on,
    input wire logic [2:0] port_six_pin_out,
    input wire logic [2:0] port_six_pin_oe,
    input wire logic bus_acknowledge,
    input wire logic bus_release_request,
    input wire logic bus_release_enable
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    // Standby guard: a standby edge reloads 0f even in wide modes
    a_wide_all_out: assert property (
        op_mode[1] && !hw_standby |=> !op_mode[1] || port_five_pin_oe == 4'hf)
        else $error("port five not all outputs in wide mode");
    a_wide_addr_out: assert property (
        op_mode[1] |-> port_five_pin_out == address_bus_upper)
        else $error("port five not driven from address bus");
    a_wide_pullup_off: assert property (
        op_mode[1] |-> port_five_pullup_on == 4'h0)
        else $error("pull-up on in wide mode");
    a_pullup_input_only: assert property (
        (port_five_pullup_on & port_five_pin_oe) == 4'h0)
        else $error("pull-up on for an output pin");
    a_standby_init: assert property (
        hw_standby |=> port_five_pullup_on == 4'h0 && port_six_pin_oe == 3'h0
        && (op_mode[1] || port_five_pin_oe == 4'h0))
        else $error("pins not initialised by standby");
    a_dir_reads_ones: assert property (
        reg_read && (reg_addr == `PORT_FIVE_DIRECTION_ADDR
        || reg_addr == `PORT_SIX_DIRECTION_ADDR) |=> reg_rdata == 8'hff)
        else $error("direction read not all ones");
    a_release_pins: assert property (
        bus_release_enable |-> port_six_pin_oe[2:1] == 2'b10
        && port_six_pin_out[2] == bus_acknowledge)
        else $error("release pins wrong");
    a_request_gated: assert property (
        !bus_release_enable |-> !bus_release_request)
        else $error("request seen while release disabled");
endmodule
bind gpio_ports_five_six gpio_ports_five_six_checker checker_inst (
    .clk, .reset_n, .hw_standby, .op_mode, .reg_addr, .reg_read, .reg_rdata,
    .address_bus_upper, .port_five_pin_out, .port_five_pin_oe,
    .port_five_pullup_on, .port_six_pin_out, .port_six_pin_oe,
    .bus_acknowledge, .bus_release_request, .bus_release_enable
);
`default_nettype wire

// File: gpio_ports_five_six_map.svh
// Register offsets, reset values and field positions of ports five and six
`ifndef GPIO_PORTS_FIVE_SIX_MAP_SVH
`define GPIO_PORTS_FIVE_SIX_MAP_SVH

`define PORT_FIVE_DIRECTION_ADDR 16'hffc8
`define PORT_SIX_DIRECTION_ADDR 16'hffc9
`define PORT_FIVE_OUTPUT_LATCH_ADDR 16'hffca
`define PORT_SIX_OUTPUT_LATCH_ADDR 16'hffcb
`define PORT_FIVE_PULLUP_CONTROL_ADDR 16'hffdb
`define BUS_RELEASE_CONTROL_ADDR 16'hffdc

`define PORT_FIVE_DIRECTION_RESET 8'h0f
`define PORT_FIVE_DIRECTION_WIDE 8'hff
`define PORT_SIX_DIRECTION_RESET 8'h80
`define PORT_FIVE_OUTPUT_LATCH_RESET 8'h00
`define PORT_SIX_OUTPUT_LATCH_RESET 8'h80
`define PORT_FIVE_PULLUP_CONTROL_RESET 8'h00
`define WRITE_ONLY_READ 8'hff
`define UNMAPPED_READ 8'h00

`define PORT_FIVE_PIN_LSB 4
`define PORT_SIX_PIN_COUNT 3
`define PORT_SIX_ACK_BIT 2
`define PORT_SIX_REQ_BIT 1
`define BUS_RELEASE_ENABLE_BIT 7

`endif

// File: gpio_ports_five_six_pkg.sv
// Types shared by the port five and six block
package gpio_ports_five_six_pkg;

    typedef enum logic [1:0] {
        mode_one_mbyte_a = 2'h0,
        mode_one_mbyte_b = 2'h1,
        mode_sixteen_mbyte_a = 2'h2,
        mode_sixteen_mbyte_b = 2'h3
    } op_mode_e;

endpackage

// File: gpio_ports_five_six_tb_top.sv
// Self-checking bench for the port five and six block
`timescale 1ns/1ps
`default_nettype none
`include "gpio_ports_five_six_map.svh"
module gpio_ports_five_six_tb_top;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic hw_standby = 1'b0;
    gpio_ports_five_six_pkg::op_mode_e op_mode =
        gpio_ports_five_six_pkg::mode_one_mbyte_a;
    logic [15:0] reg_addr = 16'h0000;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [7:0] reg_rdata;
    logic [3:0] address_bus_upper = 4'h0;
    logic bus_acknowledge = 1'b0;
    logic [3:0] five_ext = 4'h0;
    logic [2:0] six_ext = 3'h0;
    logic [3:0] five_in, five_out, five_oe, five_pu;
    logic [2:0] six_in, six_out, six_oe;
    logic release_req, release_en;
    int error_cnt = 0;
    int tests_run = 0;
    int seed = 32'h5a66b755;
    int d5, l5, pc, d6, l6;
    int addrs[6] = '{'hffc8, 'hffc9, 'hffca, 'hffcb, 'hffdb, 'hffcc};
    always #10 clk = ~clk;
    gpio_ports_five_six dut (.clk, .reset_n, .hw_standby, .op_mode,
        .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
        .address_bus_upper, .port_five_pin_in(five_in),
        .port_five_pin_out(five_out), .port_five_pin_oe(five_oe),
        .port_five_pullup_on(five_pu), .port_six_pin_in(six_in),
        .port_six_pin_out(six_out), .port_six_pin_oe(six_oe),
        .bus_acknowledge, .bus_release_request(release_req),
        .bus_release_enable(release_en));
    gpio_board_model board (.five_out, .five_oe, .five_ext, .six_out,
        .six_oe, .six_ext, .five_level(five_in), .six_level(six_in));
    // ------------------------------------------------------------
    // Compare and bus tasks
    // ------------------------------------------------------------
    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: read %h not %h", $time, got, exp);
        end
    endtask
    task automatic chk_pin(input logic [3:0] got, input logic [3:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: pins %h not %h", $time, got, exp);
        end
    endtask
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic put(input int a, input int d);
        @(posedge clk);
        reg_write <= 1'b1;
        reg_addr <= 16'(a);
        reg_wdata <= 8'(d);
        @(posedge clk);
        reg_write <= 1'b0;
        // Low nibble of port five direction is fixed, wide mode all ones
        case (a)
            'hffc8: d5 = op_mode[1] ? 'hff : ((d & 'hf0) | 'h0f);
            'hffc9: d6 = (d & 'hff) | 'h80;
            'hffca: l5 = d & 'hff;
            'hffcb: l6 = (d & 'hff) | 'h80;
            'hffdb: pc = d & 'hff;
            default: ;
        endcase
    endtask
    function automatic int exp_read(input int a);
        case (a)
            'hffc8, 'hffc9: return 'hff;
            'hffca: return ((d5 & l5) | (~d5 & {five_ext, 4'h0})) & 'hff;
            'hffcb: return (l6 & 'hf8) | (((d6 & l6) | (~d6 & six_ext)) & 7);
            'hffdb: return pc;
            default: return 0;
        endcase
    endfunction
    task automatic regs;
        logic [7:0] v;
        foreach (addrs[i]) begin
            @(posedge clk);
            reg_read <= 1'b1;
            reg_addr <= 16'(addrs[i]);
            @(posedge clk);
            reg_read <= 1'b0;
            #1 v = reg_rdata;
            chk_reg(v, 8'(exp_read(addrs[i])));
        end
    endtask
    task automatic pins;
        chk_pin(five_oe, 4'(d5 >> 4));
        chk_pin(five_out & five_oe, 4'((d5 & l5) >> 4));
        chk_pin(five_pu, 4'((pc & ~d5) >> 4));
        chk_pin({1'b0, six_oe}, 4'(d6 & 7));
    endtask
    task automatic init_model;
        d5 = 'h0f;
        l5 = 0;
        pc = 0;
        d6 = 'h80;
        l6 = 'h80;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        give_verdict();
    end
    initial begin
        init_model();
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        regs();
        pins();
        $display("test reset values done");
        repeat (60) begin
            op_mode <= gpio_ports_five_six_pkg::op_mode_e'($random(seed) & 1);
            five_ext <= 4'($random(seed));
            six_ext <= 3'($random(seed));
            put(addrs[$unsigned($random(seed)) % 6], $random(seed));
            repeat (6) @(posedge clk);
            regs();
            pins();
        end
        $display("test random access done");
        put('hffdb, 'hf0);
        put('hffc9, 'h07);
        put('hffcb, 'h7f);
        @(posedge clk);
        hw_standby <= 1'b1;
        @(posedge clk);
        hw_standby <= 1'b0;
        init_model();
        // Pins turned inputs need the synchroniser delay before reading
        repeat (6) @(posedge clk);
        regs();
        pins();
        $display("test hardware standby done");
        bus_acknowledge <= 1'b1;
        six_ext <= 3'h2;
        put(`BUS_RELEASE_CONTROL_ADDR, 'h80);
        repeat (6) @(posedge clk);
        chk_pin({release_en, six_oe}, 4'hc);
        chk_pin({release_req, six_out[2], 2'b00}, 4'hc);
        put(`BUS_RELEASE_CONTROL_ADDR, 'h00);
        $display("test bus release done");
        put('hffdb, 'hf0);
        op_mode <= gpio_ports_five_six_pkg::mode_sixteen_mbyte_b;
        address_bus_upper <= 4'h9;
        put('hffc8, 'h00);
        d5 = 'hff;
        repeat (2) @(posedge clk);
        chk_pin(five_oe, 4'hf);
        chk_pin(five_out, 4'h9);
        chk_pin(five_pu, 4'h0);
        regs();
        $display("test wide mode done");
        give_verdict();
    end
endmodule
`default_nettype wire
